/* hdl/gpd_pin_cell.sv */
// one port pin: output/enable selection, pullup gating and the read mux
// assumes ownership and peripheral drive are computed by the caller
`timescale 1ns/1ps
`default_nettype none
module gpd_pin_cell (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic latch,
   input wire logic dir,
   input wire logic pue,
   input wire logic owned,
   input wire logic per_out,
   input wire logic per_oe,
   input wire logic pin_in,
   output logic pad_out,
   output logic pad_oe,
   output logic pull_en,
   output logic read_bit
);
   logic next_oe;
   logic next_out;
   logic next_pull;

   // an owned pin ignores its direction bit for drive
   assign next_oe = owned ? per_oe : dir;
   assign next_out = owned ? per_out : latch;
   // pullup only on a non-driven input; dropped the moment it drives
   assign next_pull = pue & ~dir & ~next_oe;
   // direction still picks latch or pin for reads, even when owned
   assign read_bit = dir ? latch : pin_in;

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         pad_out <= 1'b0;
         pad_oe <= 1'b0;
         pull_en <= 1'b0;
      end else begin
         pad_out <= next_out;
         pad_oe <= next_oe;
         pull_en <= next_pull;
      end
   end
endmodule : gpd_pin_cell
`default_nettype wire

/* hdl/gpd_pkg.sv */
// constants, register map and carrier types shared by the two-port gpio block
// assumes a 32-bit classic wishbone master and peripheral enables from outside
package gpd_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // widths
   localparam int unsigned WIDE_W = 8;
   localparam int unsigned NARROW_W = 6;
   localparam int unsigned IDX_W = 6;
   localparam int unsigned DAT_W = 32;

   ////////////////////////////////////////////////////////////////////////////////
   // register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_WIDE_DATA = 6'h03;
   localparam logic [IDX_W-1:0] IDX_NARROW_DATA = 6'h08;
   localparam logic [IDX_W-1:0] IDX_WIDE_DIR = 6'h0A;
   localparam logic [IDX_W-1:0] IDX_WIDE_PUE = 6'h0B;
   localparam logic [IDX_W-1:0] IDX_NARROW_DIR = 6'h0C;
   localparam logic [IDX_W-1:0] IDX_OWNER = 6'h0D;
   localparam logic [IDX_W-1:0] IDX_PINS = 6'h0E;
   // index field position inside the byte address
   localparam int unsigned ADR_IDX_LSB = 2;

   ////////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [WIDE_W-1:0] WIDE_DIR_RST = 8'h00;
   localparam logic [WIDE_W-1:0] WIDE_PUE_RST = 8'h00;
   localparam logic [NARROW_W-1:0] NARROW_DIR_RST = 6'h00;

   ////////////////////////////////////////////////////////////////////////////////
   // pin positions of the shared functions
   localparam int unsigned WIDE_SS_BIT = 0;
   localparam int unsigned WIDE_MISO_BIT = 1;
   localparam int unsigned WIDE_MOSI_BIT = 2;
   localparam int unsigned WIDE_SCK_BIT = 3;
   localparam int unsigned WIDE_TIMA_LSB = 4;
   localparam int unsigned WIDE_TIMB_LSB = 6;
   localparam int unsigned NARROW_TXD_BIT = 0;
   localparam int unsigned NARROW_RXD_BIT = 1;
   // owner register: wide port ownership in the low byte, narrow port above it
   localparam int unsigned OWNER_NARROW_LSB = 8;

   ////////////////////////////////////////////////////////////////////////////////
   // carriers
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [31:0] adr;
      logic [3:0] sel;
      logic [DAT_W-1:0] dat;
   } gpd_wb_req_s;

   typedef struct packed {
      logic spi_enable_bit;
      logic spi_master_select_bit;
      logic sck_out;
      logic sck_oe;
      logic mosi_out;
      logic mosi_oe;
      logic miso_out;
      logic miso_oe;
   } gpd_spi_s;

   typedef struct packed {
      logic edge_level_select_hi;
      logic edge_level_select_lo;
      logic out;
      logic oe;
   } gpd_tim_ch_s;

   typedef struct packed {
      logic serial_if_enable_bit;
      logic txd;
   } gpd_sci_s;

endpackage : gpd_pkg

/* hdl/gpd_ports.sv */
// two gpio ports (8-bit wide port, 6-bit narrow port) with peripheral pin sharing
// assumes peripheral enables and drives arrive synchronous to sys_clk
//
// What this block does
// - wide port has eight read/write data latches that reset leaves untouched.
// - wide direction bit 1 drives the pin, 0 makes it input; reset clears all.
// - wide data read gives latch where direction is 1, pin level where 0.
// - data writes always update latches; input pins still read the pin.
// - wide pullup on only when its enable is 1 and direction is 0.
// - wide bits 6,7 go to timer b channels when their edge/level select is nonzero.
// - wide bits 4,5 go to timer a channels when their edge/level select is nonzero.
// - wide bit 3 carries spi clock while spi is enabled, else gpio.
// - wide bits 2,1 carry spi mosi and miso while spi is enabled, else gpio.
// - wide bit 0 is slave-select input unless spi is off or master.
// - with spi enabled, the other port's direction bit 0 never touches slave-select.
// - spi-owned wide pins ignore direction for drive but keep it for reads.
// - narrow port has six data latches that reset leaves untouched.
// - narrow bit 1 is serial receive input while serial interface is enabled.
// - narrow bit 0 is serial transmit output while serial interface is enabled.
// - serial-owned narrow pins ignore direction for drive, keep it for reads.
// - narrow direction 1 is output, 0 input; reset clears all six bits.
// - narrow data read gives latch where direction is 1, pin level where 0.
`timescale 1ns/1ps
`default_nettype none
module gpd_ports (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire gpd_pkg::gpd_wb_req_s wb_req,
   output logic wb_ack,
   output logic [gpd_pkg::DAT_W-1:0] wb_dat,
   input wire gpd_pkg::gpd_spi_s spi,
   input wire gpd_pkg::gpd_tim_ch_s [1:0] timer_a,
   input wire gpd_pkg::gpd_tim_ch_s [1:0] timer_b,
   input wire gpd_pkg::gpd_sci_s async_serial_interface,
   input wire logic [gpd_pkg::WIDE_W-1:0] wide_pin_in,
   output logic [gpd_pkg::WIDE_W-1:0] wide_pin_out,
   output logic [gpd_pkg::WIDE_W-1:0] wide_pin_oe,
   output logic [gpd_pkg::WIDE_W-1:0] wide_pullup_on,
   input wire logic [gpd_pkg::NARROW_W-1:0] narrow_pin_in,
   output logic [gpd_pkg::NARROW_W-1:0] narrow_pin_out,
   output logic [gpd_pkg::NARROW_W-1:0] narrow_pin_oe,
   output logic [gpd_pkg::WIDE_W-1:0] wide_pin_level,
   output logic [gpd_pkg::NARROW_W-1:0] narrow_pin_level
);
   import gpd_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // registers and bus wires
   logic [WIDE_W-1:0] wide_port_data;
   logic [WIDE_W-1:0] wide_port_direction;
   logic [WIDE_W-1:0] wide_port_pullup_enable;
   logic [NARROW_W-1:0] narrow_port_data;
   logic [NARROW_W-1:0] narrow_port_direction;

   logic [IDX_W-1:0] adr_idx;
   logic wr_fire;
   logic [7:0] wr_byte;
   logic [DAT_W-1:0] rd_word;
   logic adr_clean;

   logic hit_wide_data;
   logic hit_narrow_data;
   logic hit_wide_dir;
   logic hit_wide_pue;
   logic hit_narrow_dir;
   logic hit_owner;
   logic hit_pins;

   ////////////////////////////////////////////////////////////////////////////////
   // pin ownership and peripheral drive
   logic [WIDE_W-1:0] wide_owned;
   logic [WIDE_W-1:0] wide_per_out;
   logic [WIDE_W-1:0] wide_per_oe;
   logic [WIDE_W-1:0] wide_read;
   logic [NARROW_W-1:0] narrow_owned;
   logic [NARROW_W-1:0] narrow_per_out;
   logic [NARROW_W-1:0] narrow_per_oe;
   logic [NARROW_W-1:0] narrow_read;

   logic spi_on;
   logic ss_owned;
   logic [1:0] tima_on;
   logic [1:0] timb_on;
   logic sci_on;

   ////////////////////////////////////////////////////////////////////////////////
   // bus front end
   gpd_wb_slave gpd_wb_slave_inst (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .wb_req(wb_req),
      .rd_word(rd_word),
      .adr_idx(adr_idx),
      .wr_fire(wr_fire),
      .wr_byte(wr_byte),
      .wb_ack(wb_ack),
      .wb_dat(wb_dat)
   );

   // anything outside the small window, or not word aligned, is unmapped:
   // acked with zero read data and writes dropped
   assign adr_clean = (wb_req.adr[31:8] == 24'h00_0000) && (wb_req.adr[1:0] == 2'b00);

   assign hit_wide_data = adr_clean && (adr_idx == IDX_WIDE_DATA);
   assign hit_narrow_data = adr_clean && (adr_idx == IDX_NARROW_DATA);
   assign hit_wide_dir = adr_clean && (adr_idx == IDX_WIDE_DIR);
   assign hit_wide_pue = adr_clean && (adr_idx == IDX_WIDE_PUE);
   assign hit_narrow_dir = adr_clean && (adr_idx == IDX_NARROW_DIR);
   assign hit_owner = adr_clean && (adr_idx == IDX_OWNER);
   assign hit_pins = adr_clean && (adr_idx == IDX_PINS);

   ////////////////////////////////////////////////////////////////////////////////
   // read mux; only the addressed byte or field is non-zero
   always_comb begin
      rd_word = 32'h0000_0000;
      if (hit_wide_data) begin
         rd_word[WIDE_W-1:0] = wide_read;
      end
      if (hit_narrow_data) begin
         rd_word[NARROW_W-1:0] = narrow_read;
      end
      if (hit_wide_dir) begin
         rd_word[WIDE_W-1:0] = wide_port_direction;
      end
      if (hit_wide_pue) begin
         rd_word[WIDE_W-1:0] = wide_port_pullup_enable;
      end
      if (hit_narrow_dir) begin
         rd_word[NARROW_W-1:0] = narrow_port_direction;
      end
      if (hit_owner) begin
         rd_word[WIDE_W-1:0] = wide_owned;
         rd_word[OWNER_NARROW_LSB +: NARROW_W] = narrow_owned;
      end
      if (hit_pins) begin
         rd_word[WIDE_W-1:0] = wide_pin_in;
         rd_word[OWNER_NARROW_LSB +: NARROW_W] = narrow_pin_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // data latches carry no reset so a warm reset keeps the output pattern;
   // the cost is an unknown latch after power-up until software writes it
   always_ff @(posedge sys_clk) begin
      if (wr_fire && hit_wide_data) begin
         wide_port_data <= wr_byte;
      end
      if (wr_fire && hit_narrow_data) begin
         narrow_port_data <= wr_byte[NARROW_W-1:0];
      end
   end

   // direction and pullup registers
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         wide_port_direction <= WIDE_DIR_RST;
         wide_port_pullup_enable <= WIDE_PUE_RST;
         narrow_port_direction <= NARROW_DIR_RST;
      end else begin
         if (wr_fire && hit_wide_dir) begin
            wide_port_direction <= wr_byte;
         end
         if (wr_fire && hit_wide_pue) begin
            wide_port_pullup_enable <= wr_byte;
         end
         if (wr_fire && hit_narrow_dir) begin
            narrow_port_direction <= wr_byte[NARROW_W-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // wide port sharing
   assign spi_on = spi.spi_enable_bit;
   // slave-select is spi input only in slave mode; its direction comes from
   // the spi state alone, never from any other port's direction bit
   assign ss_owned = spi_on & ~spi.spi_master_select_bit;

   // a timer channel takes its pin whenever its edge/level field is non-zero
   assign tima_on[0] = timer_a[0].edge_level_select_hi | timer_a[0].edge_level_select_lo;
   assign tima_on[1] = timer_a[1].edge_level_select_hi | timer_a[1].edge_level_select_lo;
   assign timb_on[0] = timer_b[0].edge_level_select_hi | timer_b[0].edge_level_select_lo;
   assign timb_on[1] = timer_b[1].edge_level_select_hi | timer_b[1].edge_level_select_lo;

   always_comb begin
      wide_owned = '0;
      wide_per_out = '0;
      wide_per_oe = '0;
      // slave-select is a pure input while owned
      wide_owned[WIDE_SS_BIT] = ss_owned;
      wide_owned[WIDE_MISO_BIT] = spi_on;
      wide_per_out[WIDE_MISO_BIT] = spi.miso_out;
      wide_per_oe[WIDE_MISO_BIT] = spi.miso_oe;
      wide_owned[WIDE_MOSI_BIT] = spi_on;
      wide_per_out[WIDE_MOSI_BIT] = spi.mosi_out;
      wide_per_oe[WIDE_MOSI_BIT] = spi.mosi_oe;
      wide_owned[WIDE_SCK_BIT] = spi_on;
      wide_per_out[WIDE_SCK_BIT] = spi.sck_out;
      wide_per_oe[WIDE_SCK_BIT] = spi.sck_oe;
      for (int i = 0; i < 2; i++) begin
         wide_owned[WIDE_TIMA_LSB + i] = tima_on[i];
         wide_per_out[WIDE_TIMA_LSB + i] = timer_a[i].out;
         wide_per_oe[WIDE_TIMA_LSB + i] = timer_a[i].oe;
         wide_owned[WIDE_TIMB_LSB + i] = timb_on[i];
         wide_per_out[WIDE_TIMB_LSB + i] = timer_b[i].out;
         wide_per_oe[WIDE_TIMB_LSB + i] = timer_b[i].oe;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // narrow port sharing
   assign sci_on = async_serial_interface.serial_if_enable_bit;

   always_comb begin
      narrow_owned = '0;
      narrow_per_out = '0;
      narrow_per_oe = '0;
      narrow_owned[NARROW_TXD_BIT] = sci_on;
      narrow_per_out[NARROW_TXD_BIT] = async_serial_interface.txd;
      narrow_per_oe[NARROW_TXD_BIT] = 1'b1;
      // receive pin is never driven while the serial interface owns it
      narrow_owned[NARROW_RXD_BIT] = sci_on;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pin cells; the glitch-free turn-on relies on software loading the latch
   // before setting the direction bit, since drive follows the latch directly
   genvar g;
   generate
      for (g = 0; g < WIDE_W; g++) begin : g_wide
         gpd_pin_cell gpd_pin_cell_inst (
            .sys_clk(sys_clk),
            .resetn(resetn),
            .latch(wide_port_data[g]),
            .dir(wide_port_direction[g]),
            .pue(wide_port_pullup_enable[g]),
            .owned(wide_owned[g]),
            .per_out(wide_per_out[g]),
            .per_oe(wide_per_oe[g]),
            .pin_in(wide_pin_in[g]),
            .pad_out(wide_pin_out[g]),
            .pad_oe(wide_pin_oe[g]),
            .pull_en(wide_pullup_on[g]),
            .read_bit(wide_read[g])
         );
      end
      // the narrow port has no pullups; its cells see the enable tied low
      for (g = 0; g < NARROW_W; g++) begin : g_narrow
         gpd_pin_cell gpd_pin_cell_inst (
            .sys_clk(sys_clk),
            .resetn(resetn),
            .latch(narrow_port_data[g]),
            .dir(narrow_port_direction[g]),
            .pue(1'b0),
            .owned(narrow_owned[g]),
            .per_out(narrow_per_out[g]),
            .per_oe(narrow_per_oe[g]),
            .pin_in(narrow_pin_in[g]),
            .pad_out(narrow_pin_out[g]),
            .pad_oe(narrow_pin_oe[g]),
            .pull_en(),
            .read_bit(narrow_read[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // registered pin levels towards the peripherals (capture, spi, receive);
   // one cycle of delay, traded for flop-driven outputs
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         wide_pin_level <= 8'h00;
         narrow_pin_level <= 6'h00;
      end else begin
         wide_pin_level <= wide_pin_in;
         narrow_pin_level <= narrow_pin_in;
      end
   end

endmodule : gpd_ports
`default_nettype wire

/* hdl/gpd_wb_slave.sv */
// classic wishbone slave front end: address decode, ack and registered read data
// assumes the master holds its request until it samples ack
`timescale 1ns/1ps
`default_nettype none
module gpd_wb_slave (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire gpd_pkg::gpd_wb_req_s wb_req,
   input wire logic [gpd_pkg::DAT_W-1:0] rd_word,
   output logic [gpd_pkg::IDX_W-1:0] adr_idx,
   output logic wr_fire,
   output logic [7:0] wr_byte,
   output logic wb_ack,
   output logic [gpd_pkg::DAT_W-1:0] wb_dat
);
   import gpd_pkg::*;

   logic req_live;
   logic next_ack;

   assign adr_idx = wb_req.adr[ADR_IDX_LSB +: IDX_W];
   assign req_live = wb_req.cyc & wb_req.stb;
   // ack one cycle after the request, low again the cycle after
   assign next_ack = req_live & ~wb_ack;
   // write lands on the edge where the master sees ack; only lane 0 carries data
   assign wr_fire = req_live & wb_req.we & wb_ack & wb_req.sel[0];
   assign wr_byte = wb_req.dat[7:0];

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         wb_ack <= 1'b0;
         wb_dat <= 32'h0000_0000;
      end else begin
         wb_ack <= next_ack;
         if (next_ack && !wb_req.we) begin
            wb_dat <= rd_word;
         end
      end
   end
endmodule : gpd_wb_slave
`default_nettype wire

/* test/gpd_board.sv */
// board model: what the outside world shows on the port pins
// assumes pin drive, enable and pullup come straight from the gpio block
`timescale 1ns/1ps
`default_nettype none
module gpd_board (
   input wire logic [gpd_pkg::WIDE_W-1:0] wide_pin_out,
   input wire logic [gpd_pkg::WIDE_W-1:0] wide_pin_oe,
   input wire logic [gpd_pkg::WIDE_W-1:0] wide_pullup_on,
   input wire logic [gpd_pkg::WIDE_W-1:0] wide_ext,
   input wire logic [gpd_pkg::NARROW_W-1:0] narrow_pin_out,
   input wire logic [gpd_pkg::NARROW_W-1:0] narrow_pin_oe,
   input wire logic [gpd_pkg::NARROW_W-1:0] narrow_ext,
   output logic [gpd_pkg::WIDE_W-1:0] wide_pin_in,
   output logic [gpd_pkg::NARROW_W-1:0] narrow_pin_in
);
   import gpd_pkg::*;
   // a driven pin reads its own drive; a pulled-up input floats high, else board level
   assign wide_pin_in = (wide_pin_oe & wide_pin_out) | (~wide_pin_oe & wide_pullup_on)
      | (~wide_pin_oe & ~wide_pullup_on & wide_ext);
   assign narrow_pin_in = (narrow_pin_oe & narrow_pin_out) | (~narrow_pin_oe & narrow_ext);
endmodule : gpd_board
`default_nettype wire

/* test/gpd_ports_checker.sv */
// concurrent checks on the gpio block's ports
// assumes one clock domain, sys_clk, with synchronous active-low resetn
`timescale 1ns/1ps
`default_nettype none
module gpd_ports_checker (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire gpd_pkg::gpd_wb_req_s wb_req,
   input wire logic wb_ack,
   input wire gpd_pkg::gpd_spi_s spi,
   input wire gpd_pkg::gpd_tim_ch_s [1:0] timer_a,
   input wire gpd_pkg::gpd_tim_ch_s [1:0] timer_b,
   input wire gpd_pkg::gpd_sci_s async_serial_interface,
   input wire logic [gpd_pkg::WIDE_W-1:0] wide_pin_out,
   input wire logic [gpd_pkg::WIDE_W-1:0] wide_pin_oe,
   input wire logic [gpd_pkg::WIDE_W-1:0] wide_pullup_on,
   input wire logic [gpd_pkg::NARROW_W-1:0] narrow_pin_out,
   input wire logic [gpd_pkg::NARROW_W-1:0] narrow_pin_oe
);
   import gpd_pkg::*;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   ////////////////////////////////////////////////////////////
   sequence s_taken;
      wb_req.cyc && wb_req.stb && !wb_ack;
   endsequence
   sequence s_pulse;
      wb_ack ##1 !wb_ack;
   endsequence
   property p_ack; s_taken |=> s_pulse; endproperty
   a_ack: assert property (p_ack) else $error("bus ack not a single pulse");
   property p_rst; $rose(resetn) |-> wide_pin_oe == 8'h00 && narrow_pin_oe == 6'h00
      && wide_pullup_on == 8'h00; endproperty
   a_rst: assert property (p_rst) else $error("pins driven after reset");
   property p_pull; (wide_pullup_on & wide_pin_oe) == 8'h00; endproperty
   a_pull: assert property (p_pull) else $error("pullup on a driven pin");
   property p_tx; async_serial_interface.serial_if_enable_bit |=> narrow_pin_oe[0]
      && narrow_pin_out[0] == $past(async_serial_interface.txd); endproperty
   a_tx: assert property (p_tx) else $error("serial transmit pin wrong");
   property p_rx; async_serial_interface.serial_if_enable_bit |=> !narrow_pin_oe[1]; endproperty
   a_rx: assert property (p_rx) else $error("serial receive pin driven");
   property p_ss; spi.spi_enable_bit && !spi.spi_master_select_bit |=> !wide_pin_oe[0];
   endproperty
   a_ss: assert property (p_ss) else $error("slave select pin driven");
   property p_sck; spi.spi_enable_bit |=> wide_pin_oe[3] == $past(spi.sck_oe)
      && wide_pin_out[3] == $past(spi.sck_out); endproperty
   a_sck: assert property (p_sck) else $error("spi clock pin wrong");
   property p_sdat; spi.spi_enable_bit |=> wide_pin_oe[2:1] == $past({spi.mosi_oe, spi.miso_oe});
   endproperty
   a_sdat: assert property (p_sdat) else $error("spi data pin enables wrong");
   property p_timb; timer_b[0].edge_level_select_hi || timer_b[0].edge_level_select_lo
      |=> wide_pin_oe[6] == $past(timer_b[0].oe); endproperty
   a_timb: assert property (p_timb) else $error("timer b pin wrong");
   property p_tima; timer_a[1].edge_level_select_hi || timer_a[1].edge_level_select_lo
      |=> wide_pin_oe[5] == $past(timer_a[1].oe); endproperty
   a_tima: assert property (p_tima) else $error("timer a pin wrong");
endmodule : gpd_ports_checker
bind gpd_ports gpd_ports_checker gpd_ports_checker_inst (.sys_clk(sys_clk), .resetn(resetn),
   .wb_req(wb_req), .wb_ack(wb_ack), .spi(spi), .timer_a(timer_a), .timer_b(timer_b),
   .async_serial_interface(async_serial_interface), .wide_pin_out(wide_pin_out),
   .wide_pin_oe(wide_pin_oe), .wide_pullup_on(wide_pullup_on),
   .narrow_pin_out(narrow_pin_out), .narrow_pin_oe(narrow_pin_oe));
`default_nettype wire

/* test/gpd_ports_tb.sv */
// self-checking bench for the gpio block, registers reached over classic wishbone
// assumes the board model answers on the pins and the checker is bound in
`timescale 1ns/1ps
`default_nettype none
module gpd_ports_tb;
   import gpd_pkg::*;
   logic sys_clk;
   logic resetn;
   gpd_wb_req_s wb_req;
   logic wb_ack;
   logic [DAT_W-1:0] wb_dat;
   logic [DAT_W-1:0] rd;
   gpd_spi_s spi;
   gpd_tim_ch_s [1:0] timer_a;
   gpd_tim_ch_s [1:0] timer_b;
   gpd_tim_ch_s ch;
   gpd_sci_s sci;
   logic [WIDE_W-1:0] wide_pin_in, wide_pin_out, wide_pin_oe, wide_pullup_on, wide_ext, wide_lvl;
   logic [NARROW_W-1:0] narrow_pin_in, narrow_pin_out, narrow_pin_oe, narrow_ext, narrow_lvl;
   int num_errors;
   int cmp_count;

   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   gpd_ports gpd_ports_inst (.sys_clk(sys_clk), .resetn(resetn), .wb_req(wb_req),
      .wb_ack(wb_ack), .wb_dat(wb_dat), .spi(spi), .timer_a(timer_a), .timer_b(timer_b),
      .async_serial_interface(sci), .wide_pin_in(wide_pin_in), .wide_pin_out(wide_pin_out),
      .wide_pin_oe(wide_pin_oe), .wide_pullup_on(wide_pullup_on),
      .narrow_pin_in(narrow_pin_in), .narrow_pin_out(narrow_pin_out),
      .narrow_pin_oe(narrow_pin_oe), .wide_pin_level(wide_lvl), .narrow_pin_level(narrow_lvl));
   gpd_board gpd_board_inst (.wide_pin_out(wide_pin_out), .wide_pin_oe(wide_pin_oe),
      .wide_pullup_on(wide_pullup_on), .wide_ext(wide_ext), .narrow_pin_out(narrow_pin_out),
      .narrow_pin_oe(narrow_pin_oe), .narrow_ext(narrow_ext), .wide_pin_in(wide_pin_in),
      .narrow_pin_in(narrow_pin_in));

   ////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] expd);
      cmp_count++;
      if (seen !== expd) begin
         num_errors++;
         $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, expd);
      end
   endtask : check

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : complete_run

   // ack and read data are taken at the rising edge, before that edge's updates land
   task automatic wb_xfer(input logic [IDX_W-1:0] idx, input logic we, input logic [7:0] wd);
      int n;
      @(posedge sys_clk);
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {24'h00_0000, idx, 2'b00}, sel: 4'h1,
         dat: {24'h00_0000, wd}};
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (wb_ack !== 1'b1 && n < 20);
      if (wb_ack !== 1'b1) begin
         num_errors++;
         complete_run();
      end else begin
         rd = wb_dat;
         wb_req <= '0;
      end
   endtask : wb_xfer

   task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
      wb_xfer(idx, 1'b1, d);
   endtask : wr

   task automatic rdchk(input logic [IDX_W-1:0] idx, input logic [31:0] expd);
      wb_xfer(idx, 1'b0, 8'h00);
      check(rd, expd);
   endtask : rdchk

   // pin outputs follow their cause one edge later; read before this edge's updates land
   task automatic settle;
      repeat (2) @(posedge sys_clk);
   endtask : settle

   ////////////////////////////////////////////////////////////
   initial begin
      resetn = 1'b0;
      wb_req = '0;
      spi = '0;
      timer_a = '0;
      timer_b = '0;
      sci = '0;
      wide_ext = 8'hA5;
      narrow_ext = 6'h2A;
      num_errors = 0;
      cmp_count = 0;
      repeat (2) @(posedge sys_clk);
      resetn <= 1'b1;
      rdchk(IDX_WIDE_DIR, 32'h0000_0000);
      rdchk(IDX_WIDE_PUE, 32'h0000_0000);
      rdchk(IDX_NARROW_DIR, 32'h0000_0000);
      rdchk(6'h3F, 32'h0000_0000);
      $display("test reset values done");
      wr(IDX_WIDE_DATA, 8'h3C);
      rdchk(IDX_WIDE_DATA, 32'h0000_00A5);
      wr(IDX_WIDE_DIR, 8'h0F);
      rdchk(IDX_WIDE_DATA, 32'h0000_00AC);
      settle();
      check(wide_pin_oe, 8'h0F);
      check(wide_pin_out & 8'h0F, 8'h0C);
      wr(IDX_WIDE_PUE, 8'hFF);
      settle();
      check(wide_pullup_on, 8'hF0);
      rdchk(IDX_WIDE_DATA, 32'h0000_00FC);
      check(wide_lvl, 8'hFC);
      $display("test wide port done");
      wr(IDX_NARROW_DATA, 8'hD5);
      wr(IDX_NARROW_DIR, 8'h03);
      rdchk(IDX_NARROW_DATA, 32'h0000_0029);
      rdchk(IDX_NARROW_DIR, 32'h0000_0003);
      check(narrow_lvl, 6'h29);
      sci <= '{serial_if_enable_bit: 1'b1, txd: 1'b1};
      settle();
      check(narrow_pin_oe[1:0], 2'b01);
      check(narrow_pin_out[0], 1'b1);
      rdchk(IDX_NARROW_DATA, 32'h0000_0029);
      rdchk(IDX_OWNER, 32'h0000_0300);
      rdchk(IDX_PINS, 32'h0000_2BFC);
      sci <= '0;
      settle();
      check(narrow_pin_oe, 6'h03);
      $display("test narrow port done");
      spi <= '{spi_enable_bit: 1'b1, spi_master_select_bit: 1'b0, sck_out: 1'b0, sck_oe: 1'b0,
         mosi_out: 1'b0, mosi_oe: 1'b0, miso_out: 1'b1, miso_oe: 1'b1};
      settle();
      check(wide_pin_oe[3:0], 4'h2);
      rdchk(IDX_WIDE_DATA, 32'h0000_00FC);
      rdchk(IDX_OWNER, 32'h0000_000F);
      spi <= '{spi_enable_bit: 1'b1, spi_master_select_bit: 1'b1, sck_out: 1'b0, sck_oe: 1'b1,
         mosi_out: 1'b0, mosi_oe: 1'b0, miso_out: 1'b1, miso_oe: 1'b1};
      settle();
      check(wide_pin_oe[3:0], 4'hB);
      spi <= '0;
      settle();
      check(wide_pin_oe, 8'h0F);
      $display("test spi sharing done");
      for (int i = 0; i < 4; i++) begin
         for (int e = 0; e < 4; e++) begin
            ch = '{edge_level_select_hi: e[1], edge_level_select_lo: e[0], out: 1'b1, oe: 1'b1};
            if (i < 2) begin
               timer_a[i] <= ch;
            end else begin
               timer_b[i-2] <= ch;
            end
            settle();
            check(wide_pin_oe[4+i], e != 0);
         end
      end
      timer_a <= '0;
      timer_b <= '0;
      $display("test timer sharing done");
      resetn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      resetn <= 1'b1;
      rdchk(IDX_WIDE_DIR, 32'h0000_0000);
      wr(IDX_WIDE_DIR, 8'hFF);
      wr(IDX_NARROW_DIR, 8'h3F);
      rdchk(IDX_WIDE_DATA, 32'h0000_003C);
      rdchk(IDX_NARROW_DATA, 32'h0000_0015);
      $display("test latch kept over reset done");
      complete_run();
   end
endmodule : gpd_ports_tb
`default_nettype wire
